// ### common/flash_host_pkg.sv
package flash_host_pkg;
  localparam int ADDR_W = 23;
  localparam int DATA_W = 16;
  localparam logic [22:0] UNLOCK_ADDR_1 = 23'h000555;
  localparam logic [22:0] UNLOCK_ADDR_2 = 23'h0002AA;
  localparam logic [15:0] UNLOCK_DATA_1 = 16'h00AA;
  localparam logic [15:0] UNLOCK_DATA_2 = 16'h0055;
  localparam logic [15:0] CMD_ABORT_RESET = 16'h00F0;
  localparam logic [15:0] CMD_BYPASS_ENTRY = 16'h0020;
  localparam logic [15:0] CMD_BYPASS_PROGRAM = 16'h00A0;
  localparam logic [15:0] CMD_ERASE_SETUP = 16'h0080;
  localparam logic [15:0] CMD_BLOCK_ERASE = 16'h0030;
  localparam logic [15:0] CMD_CHIP_ERASE = 16'h0010;
  localparam logic [15:0] CMD_WRITE_BUFFER = 16'h0025;
  localparam logic [15:0] CMD_ENH_BUFFER = 16'h0033;
  localparam logic [15:0] CMD_BUFFER_CONFIRM = 16'h0029;
  localparam logic [15:0] CMD_CONFIG_QUERY = 16'h0098;
  localparam logic [15:0] CMD_BYPASS_EXIT_1 = 16'h0090;
  localparam logic [15:0] CMD_BYPASS_EXIT_2 = 16'h0000;
  localparam int BUFFER_WORDS = 32;
  localparam int ENH_BUFFER_WORDS = 256;
  localparam int MAX_BUFFER_CYCLES = 36;
  localparam int BUFFER_ABORT_POS = 1;
  localparam int ERROR_POS = 5;
  localparam int TOGGLE_POS = 6;
  localparam int POLL_POS = 7;
  // Bus strobe timing in clock cycles of 100 ns.
  localparam int SETUP_NS = 100;
  localparam int PULSE_NS = 100;
  localparam int CLK_NS = 100;
  localparam int SETUP_CYC = (SETUP_NS + CLK_NS - 1) / CLK_NS;
  localparam int PULSE_CYC = (PULSE_NS + CLK_NS - 1) / CLK_NS;
  localparam int READ_NS = 100;
  localparam int READ_CYC = (READ_NS + CLK_NS - 1) / CLK_NS;
  typedef enum logic [3:0] {
    OP_READ, OP_BYPASS_ENTER, OP_BYPASS_EXIT, OP_BYPASS_PROGRAM,
    OP_BLOCK_ERASE, OP_ERASE_MORE, OP_CHIP_ERASE, OP_WRITE_BUFFER,
    OP_ENH_BUFFER, OP_CONFIG_QUERY, OP_ABORT_RESET, OP_READ_RESET,
    OP_RAW_WRITE
  } op_e;
endpackage : flash_host_pkg

// ### hdl/flash_bus_cycle.sv
`timescale 1ns/10ps
`default_nettype none
// Runs one asynchronous bus write or read cycle on the flash pins.
module flash_bus_cycle (
  input wire logic clk_in,
  input wire logic srst_in,
  input wire logic start_in,
  input wire logic write_in,
  input wire logic [flash_host_pkg::ADDR_W-1:0] addr_in,
  input wire logic [flash_host_pkg::DATA_W-1:0] data_in,
  output logic done_out,
  output logic [flash_host_pkg::DATA_W-1:0] rdata_out,
  output logic [flash_host_pkg::ADDR_W-1:0] flash_addr_out,
  output logic flash_ce_n_out,
  output logic flash_oe_n_out,
  output logic flash_we_n_out,
  output logic [flash_host_pkg::DATA_W-1:0] flash_dq_out,
  output logic flash_dq_oe_n_out,
  input wire logic [flash_host_pkg::DATA_W-1:0] flash_dq_in
);
  import flash_host_pkg::*;
  typedef enum logic [1:0] {CY_IDLE, CY_SETUP, CY_PULSE, CY_HOLD} cyc_e;
  cyc_e state_ff;
  logic [7:0] cnt_ff;
  logic wr_ff;
  logic [DATA_W-1:0] dq_meta_ff;
  logic [DATA_W-1:0] dq_sync_ff;

  always_ff @(posedge clk_in) begin
    dq_meta_ff <= flash_dq_in;
    dq_sync_ff <= dq_meta_ff;
  end

  always_ff @(posedge clk_in) begin
    done_out <= 1'b0;
    if (srst_in) begin
      state_ff <= CY_IDLE;
      cnt_ff <= 8'h00;
      wr_ff <= 1'b0;
      flash_ce_n_out <= 1'b1;
      flash_oe_n_out <= 1'b1;
      flash_we_n_out <= 1'b1;
      flash_dq_oe_n_out <= 1'b1;
      flash_addr_out <= '0;
      flash_dq_out <= '0;
      rdata_out <= '0;
    end else begin
      case (state_ff)
        CY_IDLE: begin
          if (start_in) begin
            wr_ff <= write_in;
            flash_addr_out <= addr_in;
            flash_dq_out <= data_in;
            flash_ce_n_out <= 1'b0;
            flash_dq_oe_n_out <= ~write_in;
            cnt_ff <= 8'(SETUP_CYC);
            state_ff <= CY_SETUP;
          end
        end
        CY_SETUP: begin
          if (cnt_ff <= 8'h01) begin
            flash_we_n_out <= ~wr_ff;
            flash_oe_n_out <= wr_ff;
            cnt_ff <= wr_ff ? 8'(PULSE_CYC) : 8'(READ_CYC + 2);
            state_ff <= CY_PULSE;
          end else begin
            cnt_ff <= cnt_ff - 8'h01;
          end
        end
        CY_PULSE: begin
          if (cnt_ff <= 8'h01) begin
            rdata_out <= dq_sync_ff;
            flash_we_n_out <= 1'b1;
            flash_oe_n_out <= 1'b1;
            state_ff <= CY_HOLD;
          end else begin
            cnt_ff <= cnt_ff - 8'h01;
          end
        end
        default: begin
          flash_ce_n_out <= 1'b1;
          flash_dq_oe_n_out <= 1'b1;
          done_out <= 1'b1;
          state_ff <= CY_IDLE;
        end
      endcase
    end
  end
endmodule : flash_bus_cycle
`default_nettype wire

// ### hdl/flash_fast_program_cmd_ctrl.sv
`timescale 1ns/10ps
`default_nettype none
// Overview of operation
// [RL1] Device aborts on oversize word count.
// [RL2] Device aborts on load outside setup block.
// [RL3] Device aborts on load outside buffer page.
// [RL4] Device aborts when confirm is missing.
// [RL5] Device aborts on out-of-order enhanced loads.
// [RL6] Abort status: abort bit high, error low.
// [RL7] Host recovers from abort with abort-reset.
// [RL8] Abort-reset always sends all three cycles.
// [RL9] Buffer confirm programs N+1 words.
// [RL10] Enhanced confirm programs all 256 words.
// [RL11] Bypass entry is three writes, stays entered.
// [RL12] Bypass program is two writes.
// [RL13] Bypass accepts only listed commands.
// [RL14] Idle bypass reads return array data.
// [RL15] Bypass program unabortable; own bank reads status.
// [RL16] Bypass block erase two writes, repeatable.
// [RL17] Bypass block erase unabortable, bank status.
// [RL18] Bypass chip erase two writes, status reads.
// [RL19] Bypass buffer program omits unlock writes.
// [RL20] Bypass enhanced program omits two cycles.
// [RL21] Bypass query accepted at any bank address.
// [RL22] Bypass exit is two writes; reset stays.
// [RL23] Command codes are hexadecimal as listed.
// [RL24] Buffer sequence never exceeds 36 cycles; code issues up to 37 outside bypass with 32 words.
// [RL25] Stray writes in bypass are ignored.
module flash_fast_program_cmd_ctrl #(
  parameter int BUF_WORDS = flash_host_pkg::BUFFER_WORDS,
  parameter int ENH_WORDS = flash_host_pkg::ENH_BUFFER_WORDS
) (
  input wire logic clk_in,
  input wire logic srst_in,
  input wire logic req_valid_in,
  output logic req_ready_out,
  input wire flash_host_pkg::op_e req_op_in,
  input wire logic [flash_host_pkg::ADDR_W-1:0] req_addr_in,
  input wire logic [flash_host_pkg::DATA_W-1:0] req_data_in,
  input wire logic [8:0] req_count_in,
  output logic word_req_out,
  input wire logic [flash_host_pkg::DATA_W-1:0] word_data_in,
  output logic done_out,
  output logic [flash_host_pkg::DATA_W-1:0] rdata_out,
  output logic bypass_out,
  output logic abort_seen_out,
  output logic [flash_host_pkg::ADDR_W-1:0] flash_addr_out,
  output logic flash_ce_n_out,
  output logic flash_oe_n_out,
  output logic flash_we_n_out,
  output logic [flash_host_pkg::DATA_W-1:0] flash_dq_out,
  output logic flash_dq_oe_n_out,
  input wire logic [flash_host_pkg::DATA_W-1:0] flash_dq_in
);
  import flash_host_pkg::*;
  typedef enum logic [2:0] {
    ST_IDLE, ST_ISSUE, ST_WAIT, ST_WORD, ST_POLL
  } state_e;

  ////////////////////////////////////////////////////////////////////////////
  state_e state_ff;
  op_e op_ff;
  logic [ADDR_W-1:0] addr_ff;
  logic [DATA_W-1:0] data_ff;
  logic [8:0] count_ff;
  logic [8:0] step_ff;
  logic [8:0] word_ff;
  logic bypass_ff;
  logic abort_ff;
  logic cyc_start;
  logic cyc_write;
  logic [ADDR_W-1:0] cyc_addr;
  logic [DATA_W-1:0] cyc_data;
  logic cyc_done;
  logic [DATA_W-1:0] cyc_rdata;
  logic [8:0] last_step;
  logic step_is_word;

  // Returns the word count clamped to what the chosen buffer can hold.
  function automatic logic [8:0] clamp_count(input logic [8:0] cnt,
                                             input int words);
    if (cnt == 9'h000) begin
      clamp_count = 9'h001;
    end else if (int'(cnt) > words) begin
      clamp_count = 9'(words);
    end else begin
      clamp_count = cnt;
    end
  endfunction : clamp_count

  assign req_ready_out = (state_ff == ST_IDLE);
  assign bypass_out = bypass_ff;
  assign abort_seen_out = abort_ff;

  ////////////////////////////////////////////////////////////////////////////
  // Sequence length per operation: index of the last bus cycle.
  always_comb begin
    last_step = 9'h000;
    step_is_word = 1'b0;
    case (op_ff)
      OP_BYPASS_ENTER: last_step = 9'h002; // RL11
      OP_ABORT_RESET: last_step = 9'h002; // RL8
      OP_BYPASS_EXIT: last_step = 9'h001; // RL22
      OP_BYPASS_PROGRAM, OP_BLOCK_ERASE, OP_CHIP_ERASE: begin
        last_step = bypass_ff ? 9'h001 : 9'h005; // RL12 RL16 RL18
      end
      OP_WRITE_BUFFER: begin
        // Setup, count, N+1 loads and confirm take up to 37 cycles, 35 in bypass.
        last_step = count_ff + (bypass_ff ? 9'h002 : 9'h004); // RL24 RL19
        step_is_word = (step_ff >= (bypass_ff ? 9'h002 : 9'h004)) &&
                       (step_ff < last_step);
      end
      OP_ENH_BUFFER: begin
        last_step = 9'(ENH_WORDS) + (bypass_ff ? 9'h001 : 9'h003); // RL20
        step_is_word = (step_ff >= (bypass_ff ? 9'h001 : 9'h003)) &&
                       (step_ff < last_step);
      end
      default: last_step = 9'h000;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // Address and data of the current bus cycle.
  always_comb begin
    cyc_write = 1'b1;
    cyc_addr = addr_ff;
    cyc_data = data_ff;
    case (op_ff)
      OP_READ: cyc_write = 1'b0;
      OP_CONFIG_QUERY: cyc_data = CMD_CONFIG_QUERY; // RL21
      OP_RAW_WRITE: cyc_data = data_ff;
      OP_READ_RESET: cyc_data = CMD_ABORT_RESET;
      OP_BYPASS_EXIT: begin
        cyc_data = (step_ff == 9'h000) ? CMD_BYPASS_EXIT_1
                                       : CMD_BYPASS_EXIT_2;
      end
      default: begin
        cyc_addr = UNLOCK_ADDR_1;
        cyc_data = UNLOCK_DATA_1;
      end
    endcase
    if (op_ff == OP_BYPASS_ENTER || op_ff == OP_ABORT_RESET ||
        ((op_ff == OP_BYPASS_PROGRAM || op_ff == OP_BLOCK_ERASE ||
          op_ff == OP_CHIP_ERASE) && !bypass_ff) ||
        ((op_ff == OP_WRITE_BUFFER || op_ff == OP_ENH_BUFFER) &&
         !bypass_ff)) begin
      // Unlock preamble and, for six-cycle erases, its repeat.
      case (step_ff)
        9'h001, 9'h004: begin
          cyc_addr = UNLOCK_ADDR_2;
          cyc_data = UNLOCK_DATA_2;
        end
        default: begin
          cyc_addr = UNLOCK_ADDR_1;
          cyc_data = UNLOCK_DATA_1;
        end
      endcase
    end
    case (op_ff)
      OP_BYPASS_ENTER: if (step_ff == 9'h002) cyc_data = CMD_BYPASS_ENTRY;
      OP_ABORT_RESET: if (step_ff == 9'h002) cyc_data = CMD_ABORT_RESET; // RL7
      OP_BYPASS_PROGRAM: begin
        if (step_ff == last_step - 9'h001) begin
          cyc_data = CMD_BYPASS_PROGRAM;
        end else if (step_ff == last_step) begin
          cyc_addr = addr_ff;
          cyc_data = data_ff;
        end
      end
      OP_BLOCK_ERASE, OP_CHIP_ERASE: begin
        if (step_ff == (bypass_ff ? 9'h000 : 9'h002)) begin
          cyc_data = CMD_ERASE_SETUP;
        end else if (step_ff == last_step) begin
          cyc_addr = addr_ff;
          cyc_data = (op_ff == OP_BLOCK_ERASE) ? CMD_BLOCK_ERASE
                                               : CMD_CHIP_ERASE;
        end
      end
      OP_ERASE_MORE: begin
        cyc_addr = addr_ff;
        cyc_data = CMD_BLOCK_ERASE; // RL16
      end
      OP_WRITE_BUFFER, OP_ENH_BUFFER: begin
        if (step_ff == (bypass_ff ? 9'h000 : 9'h002)) begin
          cyc_addr = addr_ff;
          cyc_data = (op_ff == OP_WRITE_BUFFER) ? CMD_WRITE_BUFFER
                                                : CMD_ENH_BUFFER;
        end else if (op_ff == OP_WRITE_BUFFER &&
                     step_ff == (bypass_ff ? 9'h001 : 9'h003)) begin
          cyc_addr = addr_ff;
          cyc_data = 16'(count_ff - 9'h001); // RL1 RL9
        end else if (step_is_word) begin
          // Loads climb from the start address; write-buffer loads are not kept inside one page.
          cyc_addr = addr_ff + 23'(word_ff); // RL2 RL3 RL5
          cyc_data = word_data_in;
        end else if (step_ff == last_step) begin
          cyc_addr = addr_ff;
          cyc_data = CMD_BUFFER_CONFIRM; // RL4 RL9 RL10
        end
      end
      default: ;
    endcase
  end

  assign cyc_start = (state_ff == ST_ISSUE) || (state_ff == ST_POLL);

  ////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge clk_in) begin
    done_out <= 1'b0;
    word_req_out <= 1'b0;
    if (srst_in) begin
      state_ff <= ST_IDLE;
      op_ff <= OP_READ;
      addr_ff <= '0;
      data_ff <= '0;
      count_ff <= 9'h001;
      step_ff <= 9'h000;
      word_ff <= 9'h000;
      rdata_out <= '0;
    end else begin
      case (state_ff)
        ST_IDLE: begin
          if (req_valid_in) begin
            op_ff <= req_op_in;
            data_ff <= req_data_in;
            step_ff <= 9'h000;
            word_ff <= 9'h000;
            if (req_op_in == OP_ENH_BUFFER) begin
              // Enhanced loads start at the page base.
              addr_ff <= {req_addr_in[ADDR_W-1:8], 8'h00}; // RL5
            end else begin
              addr_ff <= req_addr_in;
            end
            count_ff <= clamp_count(req_count_in, BUF_WORDS); // RL1
            // Repeated entry and raw writes in bypass, and exit or erase-more outside it, are dropped.
            if ((bypass_ff && (req_op_in == OP_BYPASS_ENTER ||
                               req_op_in == OP_RAW_WRITE)) ||
                (!bypass_ff && (req_op_in == OP_BYPASS_EXIT ||
                                req_op_in == OP_ERASE_MORE))) begin
              done_out <= 1'b1; // RL13 RL25
            end else begin
              state_ff <= ST_ISSUE;
            end
          end
        end
        ST_ISSUE: begin
          state_ff <= ST_WAIT;
        end
        ST_WAIT: begin
          if (cyc_done) begin
            rdata_out <= cyc_rdata; // RL14 RL15 RL17
            if (step_is_word) begin
              word_ff <= word_ff + 9'h001;
              word_req_out <= 1'b1;
            end
            if (step_ff >= last_step) begin
              state_ff <= (op_ff == OP_READ) ? ST_IDLE : ST_POLL;
              if (op_ff == OP_READ) begin
                done_out <= 1'b1;
              end
            end else begin
              step_ff <= step_ff + 9'h001;
              state_ff <= ST_ISSUE;
            end
          end
        end
        default: begin
          // One status read closes each command so software sees status.
          state_ff <= ST_WORD;
          op_ff <= OP_READ;
        end
      endcase
      if (state_ff == ST_WORD && cyc_done) begin
        rdata_out <= cyc_rdata;
        done_out <= 1'b1;
        state_ff <= ST_IDLE;
      end
    end
  end

  // Tracks bypass mode and the abort signature on status reads.
  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      bypass_ff <= 1'b0;
      abort_ff <= 1'b0;
    end else if (state_ff == ST_IDLE && req_valid_in) begin
      if (req_op_in == OP_BYPASS_ENTER) begin
        bypass_ff <= 1'b1; // RL11
      end else if (req_op_in == OP_BYPASS_EXIT && bypass_ff) begin
        bypass_ff <= 1'b0; // RL22
      end
      if (req_op_in == OP_ABORT_RESET) begin
        abort_ff <= 1'b0; // RL7
      end
    end else if (cyc_done && !abort_ff) begin
      abort_ff <= cyc_rdata[BUFFER_ABORT_POS] &&
                  !cyc_rdata[ERROR_POS] &&
                  (state_ff == ST_WORD); // RL6
    end
  end

  flash_bus_cycle u_cycle (
    .clk_in(clk_in),
    .srst_in(srst_in),
    .start_in(cyc_start),
    .write_in(cyc_write && state_ff != ST_POLL),
    .addr_in(cyc_addr),
    .data_in(cyc_data),
    .done_out(cyc_done),
    .rdata_out(cyc_rdata),
    .flash_addr_out(flash_addr_out),
    .flash_ce_n_out(flash_ce_n_out),
    .flash_oe_n_out(flash_oe_n_out),
    .flash_we_n_out(flash_we_n_out),
    .flash_dq_out(flash_dq_out),
    .flash_dq_oe_n_out(flash_dq_oe_n_out),
    .flash_dq_in(flash_dq_in)
  );
endmodule : flash_fast_program_cmd_ctrl
`default_nettype wire

// ### testbench/flash_cmd_checker.sv
`timescale 1ns/10ps
`default_nettype none
module flash_cmd_checker (
  input wire logic clk_in,
  input wire logic srst_in,
  input wire logic req_valid_in,
  input wire logic req_ready_out,
  input wire flash_host_pkg::op_e req_op_in,
  input wire logic done_out,
  input wire logic bypass_out,
  input wire logic [flash_host_pkg::ADDR_W-1:0] flash_addr_out,
  input wire logic flash_ce_n_out,
  input wire logic flash_oe_n_out,
  input wire logic flash_we_n_out,
  input wire logic [flash_host_pkg::DATA_W-1:0] flash_dq_out,
  input wire logic flash_dq_oe_n_out
);
  import flash_host_pkg::*;
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (srst_in);
  //////////////////////////////////////////////////////////////////////
  reset_idle_a:
    assert property ($fell(srst_in) |-> flash_we_n_out && flash_oe_n_out
      && flash_dq_oe_n_out && !done_out && req_ready_out)
    else $error("pins not idle after reset");
  we_in_select_a:
    assert property (!flash_we_n_out |-> !flash_ce_n_out && flash_oe_n_out)
    else $error("write strobe outside chip select");
  dq_drive_a:
    assert property (!flash_we_n_out |-> !flash_dq_oe_n_out)
    else $error("data not driven during write");
  read_float_a:
    assert property (!flash_oe_n_out |-> flash_dq_oe_n_out)
    else $error("data driven during read");
  we_pulse_a:
    assert property ($fell(flash_we_n_out) |=> $rose(flash_we_n_out)
      ##1 $rose(flash_ce_n_out))
    else $error("write cycle shape wrong");
  addr_hold_a:
    assert property (!flash_we_n_out |->
      $stable(flash_addr_out) && $stable(flash_dq_out))
    else $error("address or data moved under write strobe");
  done_pulse_a:
    assert property (done_out |=> !done_out)
    else $error("done longer than one cycle");
  refuse_enter_a:
    assert property (req_valid_in && req_ready_out && bypass_out &&
      req_op_in == OP_BYPASS_ENTER |=> done_out && flash_ce_n_out)
    else $error("refused entry moved pins");
  cover property ($rose(bypass_out));
  cover property ($fell(bypass_out));
  cover property ($fell(flash_we_n_out));
endmodule : flash_cmd_checker
bind flash_fast_program_cmd_ctrl flash_cmd_checker chk (.*);
`default_nettype wire

// ### testbench/flash_device_model.sv
`timescale 1ns/10ps
`default_nettype none
module flash_device_model #(
  parameter int ENH_WORDS = 16,
  parameter int BUSY_NS = 2000
) (
  input wire logic [22:0] addr_in,
  input wire logic ce_n_in,
  input wire logic oe_n_in,
  input wire logic we_n_in,
  input wire logic [15:0] dq_in,
  output logic [15:0] dq_out
);
  import flash_host_pkg::*;
  logic [15:0] mem [logic [22:0]];
  logic [15:0] pend [logic [22:0]];
  logic [15:0] rd_q = 16'h0000, last_pd = 16'h0000;
  logic [22:0] blk = '0;
  logic [17:0] pg = '0;
  logic [2:0] busy_bank = '0;
  bit bypass_ff, abort_ff, er_ff, tog, busy_all, first;
  int ul, st, cnt, n_wr, q_seen;
  realtime busy_until = 0;
  task automatic go_busy(input logic [22:0] a, input bit all);
    busy_until = $realtime + BUSY_NS;
    busy_bank = a[22:20];
    busy_all = all;
  endtask : go_busy
  task automatic erase(input logic [22:0] a);
    foreach (mem[k]) if (k[22:16] == a[22:16]) mem[k] = 16'hFFFF;
    go_busy(a, 0);
    er_ff = 1;
  endtask : erase
  task automatic wr(input logic [22:0] a, input logic [15:0] d);
    bit more;
    more = er_ff;
    er_ff = 0;
    if (abort_ff) begin
      if (ul == 2 && a == UNLOCK_ADDR_1 && d == CMD_ABORT_RESET) abort_ff = 0;
      return;
    end
    case (st)
      0: begin
        blk = a;
        cnt = 0;
        first = 1;
        pend.delete();
        if (bypass_ff && more && d == CMD_BLOCK_ERASE) erase(a);
        else if (ul == 2 && d == CMD_BYPASS_ENTRY) bypass_ff = 1;
        else if (ul == 2 || bypass_ff) begin
          if (d == CMD_WRITE_BUFFER) st = 3;
          else if (d == CMD_ENH_BUFFER) st = 7;
          else if (bypass_ff && d == CMD_BYPASS_PROGRAM) st = 1;
          else if (bypass_ff && d == CMD_ERASE_SETUP) st = 2;
          else if (bypass_ff && d == CMD_BYPASS_EXIT_1) st = 6;
          else if (bypass_ff && d == CMD_CONFIG_QUERY) q_seen++;
        end
      end
      1: begin
        mem[a] = d;
        go_busy(a, 0);
        st = 0;
      end
      2: begin
        if (d == CMD_BLOCK_ERASE) erase(a);
        if (d == CMD_CHIP_ERASE) begin
          foreach (mem[k]) mem[k] = 16'hFFFF;
          go_busy(a, 1);
        end
        st = 0;
      end
      3: begin
        cnt = d + 1;
        last_pd = d;
        st = 4;
        if (cnt > BUFFER_WORDS) abort_ff = 1;
      end
      4, 7: begin
        last_pd = d;
        if (a[22:16] != blk[22:16]) abort_ff = 1;
        else if (st == 4 && !first && a[22:5] != pg) abort_ff = 1;
        else if (st == 7 && a[7:0] != cnt[7:0]) abort_ff = 1;
        pend[a] = d;
        pg = first ? a[22:5] : pg;
        first = 0;
        cnt = (st == 4) ? cnt - 1 : cnt + 1;
        if ((st == 4) ? cnt == 0 : cnt == ENH_WORDS) st = 5;
      end
      5: begin
        if (d == CMD_BUFFER_CONFIRM) begin
          foreach (pend[k]) mem[k] = pend[k];
          go_busy(a, 0);
        end else abort_ff = 1;
        st = 0;
      end
      6: begin
        if (d == CMD_BYPASS_EXIT_2) bypass_ff = 0;
        st = 0;
      end
      default: st = 0;
    endcase
    if (abort_ff) st = 0;
  endtask : wr
  //////////////////////////////////////////////////////////////////////
  always @(posedge we_n_in) begin
    if (!ce_n_in) begin
      n_wr++;
      wr(addr_in, dq_in);
      ul = (addr_in == UNLOCK_ADDR_1 && dq_in == UNLOCK_DATA_1) ? 1 :
        (ul == 1 && addr_in == UNLOCK_ADDR_2 && dq_in == UNLOCK_DATA_2)
        ? 2 : 0;
    end
  end
  always @(negedge oe_n_in) begin
    if (abort_ff || ($realtime < busy_until &&
        (busy_all || addr_in[22:20] == busy_bank))) begin
      tog = !tog;
      rd_q = 16'h0000;
      rd_q[POLL_POS] = !last_pd[7];
      rd_q[TOGGLE_POS] = tog;
      rd_q[BUFFER_ABORT_POS] = abort_ff;
    end else rd_q = mem.exists(addr_in) ? mem[addr_in] : 16'hFFFF;
  end
  // A released bus shows the inverse of the last word, not a held value.
  assign dq_out = (!ce_n_in && !oe_n_in) ? rd_q : ~rd_q;
endmodule : flash_device_model
`default_nettype wire

// ### testbench/flash_fast_program_cmd_ctrl_test.sv
`timescale 1ns/10ps
`default_nettype none
module flash_fast_program_cmd_ctrl_test;
  import flash_host_pkg::*;
  localparam int ENH = 16;
  localparam logic [22:0] PA = 23'h010000, QA = 23'h500000;
  localparam logic [22:0] WA = 23'h020040, EA = 23'h030100;
  localparam logic [22:0] BA = 23'h040000, BB = 23'h050000;
  logic clk_in = 0, srst_in = 1, req_valid_in = 0;
  op_e req_op_in = OP_READ;
  logic [22:0] req_addr_in = '0, f_addr;
  logic [15:0] req_data_in = '0, word_data_in = 16'h0100;
  logic [15:0] rdata_out, f_dq, m_dq, bus_dq;
  logic [8:0] req_count_in = 9'h001;
  logic req_ready_out, word_req_out, done_out, bypass_out, abort_seen_out;
  logic f_ce_n, f_oe_n, f_we_n, f_dq_oe_n;
  int n_fail = 0, tests_run = 0;
  assign bus_dq = f_dq_oe_n ? m_dq : f_dq;
  flash_fast_program_cmd_ctrl #(.ENH_WORDS(ENH)) dut (
    .clk_in(clk_in), .srst_in(srst_in), .req_valid_in(req_valid_in),
    .req_ready_out(req_ready_out), .req_op_in(req_op_in),
    .req_addr_in(req_addr_in), .req_data_in(req_data_in),
    .req_count_in(req_count_in), .word_req_out(word_req_out),
    .word_data_in(word_data_in), .done_out(done_out),
    .rdata_out(rdata_out), .bypass_out(bypass_out),
    .abort_seen_out(abort_seen_out), .flash_addr_out(f_addr),
    .flash_ce_n_out(f_ce_n), .flash_oe_n_out(f_oe_n),
    .flash_we_n_out(f_we_n), .flash_dq_out(f_dq),
    .flash_dq_oe_n_out(f_dq_oe_n), .flash_dq_in(bus_dq));
  flash_device_model #(.ENH_WORDS(ENH)) dev (.addr_in(f_addr),
    .ce_n_in(f_ce_n), .oe_n_in(f_oe_n), .we_n_in(f_we_n),
    .dq_in(bus_dq), .dq_out(m_dq));
  //////////////////////////////////////////////////////////////////////
  task automatic check(input string what, input logic [31:0] seen,
      input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      n_fail++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic op(input op_e o, input logic [22:0] a,
      input logic [15:0] d = 16'h0000, input logic [8:0] c = 9'h001);
    int t;
    @(negedge clk_in);
    req_op_in = o;
    req_addr_in = a;
    req_data_in = d;
    req_count_in = c;
    req_valid_in = 1'b1;
    do @(posedge clk_in); while (req_ready_out !== 1'b1);
    @(negedge clk_in);
    req_valid_in = 1'b0;
    for (t = 0; t < 5000 && done_out !== 1'b1; t++) @(negedge clk_in);
    check("request done", done_out, 1'b1);
  endtask : op
  task automatic abort_case(input logic [15:0] su, input logic [22:0] a1,
      input logic [15:0] d1, input logic [22:0] a2, input logic [15:0] d2,
      input logic [22:0] a3, input logic [15:0] d3);
    logic t1;
    op(OP_RAW_WRITE, UNLOCK_ADDR_1, UNLOCK_DATA_1);
    op(OP_RAW_WRITE, UNLOCK_ADDR_2, UNLOCK_DATA_2);
    op(OP_RAW_WRITE, BA, su);
    op(OP_RAW_WRITE, a1, d1);
    op(OP_RAW_WRITE, a2, d2);
    op(OP_RAW_WRITE, a3, d3);
    op(OP_READ, BA);
    t1 = rdata_out[TOGGLE_POS];
    check("abort bit", rdata_out[BUFFER_ABORT_POS], 1'b1);
    check("error bit", rdata_out[ERROR_POS], 1'b0);
    check("polling bit", rdata_out[POLL_POS], 1'b1);
    check("abort seen", abort_seen_out, 1'b1);
    op(OP_READ, BA);
    check("toggle bit", rdata_out[TOGGLE_POS], !t1);
    dev.n_wr = 0;
    op(OP_ABORT_RESET, BA);
    check("reset writes", dev.n_wr, 3);
    op(OP_READ, BA);
    check("read mode back", rdata_out, 16'hFFFF);
  endtask : abort_case
  task automatic test_done();
    $display("Comparisons %0d mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : test_done
  //////////////////////////////////////////////////////////////////////
  initial forever #50 clk_in = ~clk_in;
  always @(negedge clk_in) begin
    if (word_req_out === 1'b1) word_data_in <= word_data_in + 16'h0001;
  end
  initial begin
    repeat (20000) @(posedge clk_in);
    n_fail++;
    $display("Error watchdog expected finish seen timeout");
    test_done();
  end
  initial begin
    int n;
    dev.mem[QA] = 16'h5A5A;
    repeat (20) @(posedge clk_in);
    @(negedge clk_in) srst_in = 1'b0;
    abort_case(16'h0025, BA, 16'h0040, BA, 16'h0000, BA, 16'h0000);
    abort_case(16'h0025, BA, 16'h0001, BB, 16'h0011, BA, 16'h0000);
    abort_case(16'h0025, BA, 16'h0001, BA, 16'h0011, BA + 23'h20, 16'h0012);
    abort_case(16'h0025, BA, 16'h0000, BA, 16'h0011, BA, 16'h0030);
    abort_case(16'h0033, BA + 23'h1, 16'h0011, BA, 16'h0000, BA, 16'h0000);
    dev.n_wr = 0;
    op(OP_BYPASS_ENTER, UNLOCK_ADDR_1);
    check("enter writes", dev.n_wr, 3);
    check("bypass flag", bypass_out, 1'b1);
    op(OP_BYPASS_ENTER, UNLOCK_ADDR_1);
    op(OP_READ_RESET, UNLOCK_ADDR_1);
    check("bypass kept", dev.bypass_ff, 1'b1);
    dev.n_wr = 0;
    op(OP_BYPASS_PROGRAM, PA, 16'h1234);
    check("program writes", dev.n_wr, 2);
    op(OP_READ, QA);
    check("other bank read", rdata_out, 16'h5A5A);
    repeat (30) @(negedge clk_in);
    op(OP_READ, PA);
    check("bypass array read", rdata_out, 16'h1234);
    for (n = 1; n <= 32; n += 31) begin
      word_data_in = 16'h0100;
      dev.n_wr = 0;
      op(OP_WRITE_BUFFER, WA, 16'h0000, 9'(n));
      check("buffer writes", dev.n_wr, n + 3);
      repeat (30) @(negedge clk_in);
      op(OP_READ, WA + 23'(n - 1));
      check("buffer last word", rdata_out, 16'h00FF + 16'(n));
    end
    word_data_in = 16'h0200;
    dev.n_wr = 0;
    op(OP_ENH_BUFFER, EA);
    check("enhanced writes", dev.n_wr, ENH + 2);
    repeat (30) @(negedge clk_in);
    op(OP_READ, EA + 23'(ENH - 1));
    check("enhanced last", rdata_out, 16'h01FF + 16'(ENH));
    op(OP_CONFIG_QUERY, 23'h300123);
    check("query taken", dev.q_seen, 1);
    dev.n_wr = 0;
    op(OP_BLOCK_ERASE, PA);
    op(OP_ERASE_MORE, EA);
    check("erase writes", dev.n_wr, 3);
    repeat (30) @(negedge clk_in);
    op(OP_READ, EA);
    check("added block erased", rdata_out, 16'hFFFF);
    dev.n_wr = 0;
    op(OP_CHIP_ERASE, PA);
    check("chip erase writes", dev.n_wr, 2);
    repeat (30) @(negedge clk_in);
    op(OP_READ, QA);
    check("chip erased", rdata_out, 16'hFFFF);
    dev.n_wr = 0;
    op(OP_BYPASS_EXIT, PA);
    check("exit writes", dev.n_wr, 2);
    check("bypass left", bypass_out, 1'b0);
    op(OP_ERASE_MORE, PA);
    check("refused outside", dev.n_wr, 2);
    test_done();
  end
endmodule : flash_fast_program_cmd_ctrl_test
`default_nettype wire
